/* bench/rcs_rx_mac.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_rx_mac (
  // Clock
  input wire logic sys_clk,
  // Receive side seen by the register block
  output logic carrierSense,
  output logic rxDataPending,
  output logic rxOverflow,
  output logic rxUnderflow
);
  initial {carrierSense, rxDataPending, rxOverflow, rxUnderflow} = 4'h0;
  // ----------------------------------------
  // Frame: carrier for 3 cycles, then a tail
  // ----------------------------------------
  task automatic frame(input int tail);
    @(negedge sys_clk) carrierSense = 1'b1;
    repeat (3) @(negedge sys_clk);
    carrierSense = 1'b0;
    rxDataPending = 1'b1;
    repeat (tail) @(negedge sys_clk);
    rxDataPending = 1'b0;
  endtask : frame
  // One-cycle pulse, as the FIFO flags it
  task automatic fifo_event(input logic unf);
    @(negedge sys_clk);
    if (unf) rxUnderflow = 1'b1;
    else rxOverflow = 1'b1;
    @(negedge sys_clk);
    {rxOverflow, rxUnderflow} = 2'h0;
  endtask : fifo_event
endmodule : rcs_rx_mac
`default_nettype wire

/* bench/rmii_control_status_reg_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rmii_control_status_reg_test;
  import rcs_pkg::*;
  logic sys_clk, nrst, slaveStrap, txClkShiftEn, refClk50Sel, crsDv;
  logic carrierSense, rxDataPending, rxOverflow, rxUnderflow;
  rcs_req_s regReq;
  logic [15:0] regRdData;
  logic [1:0] ebufSize;
  logic [3:0] ebufTolBits;
  logic [3:0] tolTab [4] = '{4'he, 4'h2, 4'h6, 4'ha};
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  rcs_ctrl_status i_rcs_ctrl_status (.sys_clk(sys_clk), .nrst(nrst), .slaveStrap(slaveStrap), .regReq(regReq),
    .regRdData(regRdData), .rxOverflow(rxOverflow), .rxUnderflow(rxUnderflow), .carrierSense(carrierSense),
    .rxDataPending(rxDataPending), .txClkShiftEn(txClkShiftEn), .refClk50Sel(refClk50Sel),
    .ebufSize(ebufSize), .ebufTolBits(ebufTolBits), .crsDv(crsDv));
  rcs_rx_mac i_rcs_rx_mac (.sys_clk(sys_clk), .carrierSense(carrierSense), .rxDataPending(rxDataPending),
    .rxOverflow(rxOverflow), .rxUnderflow(rxUnderflow));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Checks and register access
  // ----------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
    @(negedge sys_clk);
    regReq = '{addr: a, wrEn: w, rdEn: ~w, wrData: d};
    @(negedge sys_clk);
    regReq.wrEn = 1'b0;
    regReq.rdEn = 1'b0;
  endtask : access
  task automatic rd(input logic [15:0] exp);
    access(RCS_ADDR, 1'b0, 16'h0);
    chk("register", regRdData, exp);
  endtask : rd
  // Carrier drop with data pending, tail of 4 cycles
  task automatic frame_check(input logic rev);
    fork
      i_rcs_rx_mac.frame(4);
      begin
        @(negedge sys_clk);
        for (int k = 1; k <= 8; k++)
        begin
          @(negedge sys_clk);
          chk("crsDv", crsDv, {15'h0, k < 4 || (k < 8 && (rev || k[0]))});
        end
      end
    join
  endtask : frame_check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    regReq = '0;
    nrst = 1'b0;
    slaveStrap = 1'b1;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    chk("refClk50Sel", refClk50Sel, 16'h1);
    chk("ebufTolBits", ebufTolBits, 16'h2);
    rd(16'h008d);
    access(RCS_ADDR, 1'b1, 16'hffff);
    chk("txClkShiftEn", txClkShiftEn, 16'h1);
    rd(16'h019f);
    access(5'h18, 1'b1, 16'h0);
    access(5'h18, 1'b0, 16'h0);
    chk("unmapped", regRdData, 16'h019f);
    for (int c = 0; c < 4; c++)
    begin
      access(RCS_ADDR, 1'b1, 16'(c));
      chk("ebufTolBits", ebufTolBits, tolTab[c]);
      chk("ebufSize", ebufSize, 16'(c));
    end
    chk("refClk50Sel", refClk50Sel, 16'h0);
    chk("txClkShiftEn", txClkShiftEn, 16'h0);
    frame_check(1'b0);
    access(RCS_ADDR, 1'b1, 16'h0090);
    frame_check(1'b1);
    // Read one cycle after the event
    fork
      i_rcs_rx_mac.fifo_event(1'b0);
      begin
        @(negedge sys_clk);
        rd(16'h0094);
      end
    join
    rd(16'h009c);
    // Event in the read cycle must survive the clear
    fork
      i_rcs_rx_mac.fifo_event(1'b0);
      rd(16'h009c);
    join
    rd(16'h0094);
    rd(16'h009c);
    fork
      i_rcs_rx_mac.fifo_event(1'b1);
      begin
        @(negedge sys_clk);
        rd(16'h0098);
      end
    join
    rd(16'h009c);
    // Second reset in master mode
    nrst = 1'b0;
    slaveStrap = 1'b0;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    chk("refClk50Sel", refClk50Sel, 16'h0);
    rd(16'h000d);
    access(RCS_ADDR, 1'b1, 16'h0100);
    chk("txClkShiftEn", txClkShiftEn, 16'h0);
    rd(16'h010c);
    print_verdict();
  end
endmodule : rmii_control_status_reg_test
`default_nettype wire

/* rtl/rcs_ctrl_status.sv */
// What this block does
// R1: The transmit clock shift takes effect only in slave mode and is ignored in master mode.
// R2: Shift field 1 shifts the internal transmit clock, 0 (the reset value) applies no shift.
// R3: Clock select 0 means a 25 MHz reference, 1 means a 50 MHz oscillator reference.
// R4: Clock select is loaded from the master/slave strap at reset and may be rewritten later.
// R5: Revision field 0 makes CRS_DV toggle at packet end once carrier has dropped.
// R6: Revision field 1 holds CRS_DV steady until the last receive data has gone out.
// R7: The overflow status bit reads 0 once an overflow is seen and 1 otherwise.
// R8: A read-only status bit reports receive FIFO underflow.
// R9: The underflow status bit reads 0 once an underflow is seen and 1 otherwise.
// R10: The buffer size field selects 14, 2 (reset), 6 or 10 bits of tolerance for codes 0..3.
// R11: Bits 15 to 9, 6 and 5 read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module rcs_ctrl_status
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Strap, 1 selects slave mode
  input wire logic slaveStrap,
  // Management register port
  input wire rcs_pkg::rcs_req_s regReq,
  output logic [15:0] regRdData,
  // Receive FIFO events and receive state
  input wire logic rxOverflow,
  input wire logic rxUnderflow,
  input wire logic carrierSense,
  input wire logic rxDataPending,
  // Controls to the datapath
  output logic txClkShiftEn,
  output logic refClk50Sel,
  output logic [1:0] ebufSize,
  output logic [3:0] ebufTolBits,
  output logic crsDv
);
  import rcs_pkg::*;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [3:0] tolOf(input logic [1:0] code);
    unique case (code)
      2'h0: tolOf = RCS_TOL_0;
      2'h1: tolOf = RCS_TOL_1;
      2'h2: tolOf = RCS_TOL_2;
      2'h3: tolOf = RCS_TOL_3;
    endcase
  endfunction : tolOf

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic slaveMode_ff, nxt_slaveMode;
  logic txShift_ff, nxt_txShift;
  logic clkSel_ff, nxt_clkSel;
  logic revSel_ff, nxt_revSel;
  logic [1:0] ebuf_ff, nxt_ebuf;
  logic ovfSeen_ff, nxt_ovfSeen;
  logic unfSeen_ff, nxt_unfSeen;
  logic [15:0] rdData_ff, nxt_rdData;
  logic hit, wr, rd;
  logic [15:0] regView;

  always_comb
  begin
    hit = (regReq.addr == RCS_ADDR);
    wr = hit && regReq.wrEn;
    rd = hit && regReq.rdEn;
    regView = 16'h0000; // R11
    regView[RCS_BIT_TXSHIFT] = txShift_ff;
    regView[RCS_BIT_CLKSEL] = clkSel_ff;
    regView[RCS_BIT_REVSEL] = revSel_ff;
    regView[RCS_BIT_OVF] = ~ovfSeen_ff; // R7
    regView[RCS_BIT_UNF] = ~unfSeen_ff; // R8 R9
    regView[RCS_EBUF_LSB +: 2] = ebuf_ff;
    nxt_slaveMode = slaveMode_ff;
    nxt_txShift = txShift_ff;
    nxt_clkSel = clkSel_ff;
    nxt_revSel = revSel_ff;
    nxt_ebuf = ebuf_ff;
    nxt_rdData = rd ? regView : rdData_ff;
    if (wr)
    begin
      // Only writable fields are taken; each field is picked from its own wrData bits
      nxt_txShift = regReq.wrData[RCS_BIT_TXSHIFT] & RCS_WR_MASK[RCS_BIT_TXSHIFT];
      nxt_clkSel = regReq.wrData[RCS_BIT_CLKSEL]; // R4
      nxt_revSel = regReq.wrData[RCS_BIT_REVSEL];
      nxt_ebuf = regReq.wrData[RCS_EBUF_LSB +: 2];
    end
    // Sticky, cleared by a read; a new event in the read cycle wins
    nxt_ovfSeen = rxOverflow | (ovfSeen_ff & ~rd); // R7
    nxt_unfSeen = rxUnderflow | (unfSeen_ff & ~rd); // R9
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      // Synchronous reset, so the strap can be caught here
      slaveMode_ff <= slaveStrap;
      clkSel_ff <= slaveStrap; // R4
      txShift_ff <= RCS_RST_TXSHIFT; // R2
      revSel_ff <= RCS_RST_REVSEL;
      ebuf_ff <= RCS_RST_EBUF; // R10
      ovfSeen_ff <= 1'b0;
      unfSeen_ff <= 1'b0;
      rdData_ff <= 16'h0000;
    end
    else
    begin
      slaveMode_ff <= nxt_slaveMode;
      clkSel_ff <= nxt_clkSel;
      txShift_ff <= nxt_txShift;
      revSel_ff <= nxt_revSel;
      ebuf_ff <= nxt_ebuf;
      ovfSeen_ff <= nxt_ovfSeen;
      unfSeen_ff <= nxt_unfSeen;
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;
  assign txClkShiftEn = txShift_ff & slaveMode_ff; // R1 R2
  assign refClk50Sel = clkSel_ff; // R3
  assign ebufSize = ebuf_ff;
  assign ebufTolBits = tolOf(ebuf_ff); // R10

  // ----------------------------------------
  // Carrier sense / data valid
  // ----------------------------------------
  rcs_crs_e crsSt_ff, nxt_crsSt;
  logic crsDv_ff, nxt_crsDv;

  always_comb
  begin
    nxt_crsSt = crsSt_ff;
    nxt_crsDv = crsDv_ff;
    unique case (crsSt_ff)
      RCS_IDLE:
      begin
        nxt_crsDv = carrierSense;
        if (carrierSense)
          nxt_crsSt = RCS_HOLD;
      end
      RCS_HOLD:
      begin
        nxt_crsDv = 1'b1;
        if (!carrierSense)
        begin
          if (rxDataPending)
          begin
            nxt_crsSt = RCS_DRAIN;
            nxt_crsDv = revSel_ff; // R5 R6
          end
          else
          begin
            nxt_crsSt = RCS_IDLE;
            nxt_crsDv = 1'b0;
          end
        end
      end
      RCS_DRAIN:
      begin
        // Toggling tells a 1.2 MAC carrier is gone while data remains
        nxt_crsDv = revSel_ff ? 1'b1 : ~crsDv_ff; // R5 R6
        if (!rxDataPending)
        begin
          nxt_crsSt = RCS_IDLE;
          nxt_crsDv = 1'b0;
        end
      end
      default:
      begin
        nxt_crsSt = RCS_IDLE;
        nxt_crsDv = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      crsSt_ff <= RCS_IDLE;
      crsDv_ff <= 1'b0;
    end
    else
    begin
      crsSt_ff <= nxt_crsSt;
      crsDv_ff <= nxt_crsDv;
    end
  end

  assign crsDv = crsDv_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_shift_master_off: assert property (!slaveMode_ff |-> !txClkShiftEn) // R1
    else $error("Tx clock shift active in master mode");
  a_shift_follow: assert property (slaveMode_ff && wr |=> txClkShiftEn == $past(regReq.wrData[RCS_BIT_TXSHIFT])) // R2
    else $error("Tx clock shift does not follow write");
  a_clksel_write: assert property (wr |=> refClk50Sel == $past(regReq.wrData[RCS_BIT_CLKSEL])) // R3 R4
    else $error("Clock select write lost");
  a_toggle_drain: assert property (crsSt_ff == RCS_DRAIN && !revSel_ff && rxDataPending
    |=> crsDv != $past(crsDv)) // R5
    else $error("CRS_DV did not toggle while draining");
  a_hold_drain: assert property (crsSt_ff == RCS_DRAIN && revSel_ff && rxDataPending
    |=> crsDv) // R6
    else $error("CRS_DV dropped before data end");
  a_ovf_report: assert property (rxOverflow ##1 rd |=> !regRdData[RCS_BIT_OVF]) // R7
    else $error("Overflow not reported");
  a_unf_report: assert property (rxUnderflow ##1 rd |=> !regRdData[RCS_BIT_UNF]) // R8 R9
    else $error("Underflow not reported");
  a_unf_normal: assert property (!unfSeen_ff && rd |=> regRdData[RCS_BIT_UNF]) // R9
    else $error("Underflow bit low in normal state");
  a_tol_code: assert property (ebufSize == 2'h0 |-> ebufTolBits == 4'he) // R10
    else $error("Tolerance decode wrong for code 0");
  a_reserved_zero: assert property (rd |=> (regRdData & 16'hfe60) == 16'h0000) // R11
    else $error("Reserved bits not zero");
endmodule : rcs_ctrl_status
`default_nettype wire

/* rtl/rcs_pkg.sv */
`default_nettype none
package rcs_pkg;
  // Register address and layout
  localparam logic [4:0] RCS_ADDR = 5'h17;
  localparam int RCS_BIT_TXSHIFT = 8;
  localparam int RCS_BIT_CLKSEL = 7;
  localparam int RCS_BIT_REVSEL = 4;
  localparam int RCS_BIT_OVF = 3;
  localparam int RCS_BIT_UNF = 2;
  localparam int RCS_EBUF_LSB = 0;
  localparam logic [15:0] RCS_WR_MASK = 16'h0193;
  // Reset values
  localparam logic RCS_RST_TXSHIFT = 1'h0;
  localparam logic RCS_RST_REVSEL = 1'h0;
  localparam logic [1:0] RCS_RST_EBUF = 2'h1;
  // Elasticity tolerance in bits per size code
  localparam logic [3:0] RCS_TOL_0 = 4'he;
  localparam logic [3:0] RCS_TOL_1 = 4'h2;
  localparam logic [3:0] RCS_TOL_2 = 4'h6;
  localparam logic [3:0] RCS_TOL_3 = 4'ha;

  typedef struct packed {
    logic [4:0] addr;
    logic wrEn;
    logic rdEn;
    logic [15:0] wrData;
  } rcs_req_s;

  typedef enum logic [2:0] {
    RCS_IDLE = 3'b001,
    RCS_DRAIN = 3'b010,
    RCS_HOLD = 3'b100
  } rcs_crs_e;
endpackage : rcs_pkg
`default_nettype wire
